// ---- src/isct_pkg.sv ----
`default_nettype none
// ********************************************************
// register map and field layout
// ********************************************************
package isct_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h0C;
  localparam logic [7:0] TIMING_OFS = 8'h0D;
  localparam logic [7:0] TIMEOUT_OFS = 8'h0E;
  localparam logic [7:0] TXDATA_OFS = 8'h10;
  localparam logic [7:0] STATE_OFS = 8'h11;
  localparam logic [7:0] INT_STAT_OFS = 8'h12;
  localparam logic [7:0] INT_MASK_OFS = 8'h13;

  localparam int CTRL_EN = 0;
  localparam int CTRL_MST = 1;
  localparam int CTRL_STRS = 4;
  localparam int CTRL_START = 6;
  localparam int CTRL_STOP = 7;
  localparam int CTRL_GCEN = 8;
  localparam int CTRL_STREN = 9;
  localparam int CTRL_ABORT = 15;

  localparam int ST_BUSY = 0;
  localparam int ST_ACK = 1;
  localparam int ST_TXPEND = 2;
  localparam int ST_SCL = 3;
  localparam int ST_SDA = 4;

  localparam int INT_START = 0;
  localparam int INT_STOP = 1;
  localparam int INT_TIMEOUT = 2;
  localparam int INT_GCALL = 3;
  localparam int INT_STRETCH = 4;
  localparam int INT_W = 5;

  // ********************************************************
  // reset values and counts
  // ********************************************************
  localparam logic [15:0] TIMING_RESET = 16'h0204;
  localparam logic [7:0] TIMEOUT_RESET = 8'h00;
  localparam logic [7:0] LOW_MIN = 8'h04;
  localparam logic [7:0] HIGH_MIN = 8'h02;
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic [3:0] STRETCH_AT_8 = 4'h8;
  localparam logic [3:0] STRETCH_AT_9 = 4'h9;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
endpackage
`default_nettype wire

// ---- src/isct_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module isct_top #(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic IRQ_O
);
  typedef enum logic [2:0] {
    M_IDLE,
    M_START,
    M_HOLD,
    M_LOW,
    M_HIGH,
    M_STOP_LOW,
    M_STOP_HIGH,
    M_STOP_END
  } isct_mstate_t;

  if (ADDR_W < 5 || ADDR_W > 16)
  begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 16");
  end

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic hit(input logic [7:0] ofs);
    return ADDR_I == ADDR_W'(ofs);
  endfunction

  function automatic logic [7:0] at_least(input logic [7:0] v, input logic [7:0] floor_v);
    return (v < floor_v) ? floor_v : v;
  endfunction

  localparam int INT_W_L = isct_pkg::INT_W;

  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic ctl_enable, ctl_master, ctl_strs, ctl_start, ctl_stop;
  logic ctl_gcen, ctl_stren, ctl_abort;
  logic next_enable, next_master;
  logic [15:0] timing;
  logic [7:0] to_limit;
  logic [7:0] tx_data;
  logic tx_pending;
  logic [INT_W_L-1:0] int_status;
  logic [INT_W_L-1:0] int_mask;
  logic [INT_W_L-1:0] events;
  logic [15:0] next_rdata;
  isct_mstate_t m_state;
  logic [7:0] m_cnt;
  logic [3:0] m_bit;
  logic [7:0] m_shift;
  logic m_scl_low, m_sda_low, last_ack;
  logic bus_busy, busy;
  logic s_active, s_ack, s_hold;
  logic [3:0] s_cnt;
  logic [3:0] s_fall_no;
  logic [7:0] s_shift;
  logic [18:0] to_cnt;
  logic [18:0] to_span;
  logic [7:0] lo_eff, hi_eff;
  logic ctrl_wr, slave_on;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic m_start_done, m_stop_done, to_expire, gc_ev, stretch_ev;
  logic [3:0] stretch_at;

  // ********************************************************
  // pin synchronisers and bus conditions
  // ********************************************************
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_meta <= SCL_I;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= SDA_I;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign scl_rise = scl_sync && !scl_prev;
  assign scl_fall = !scl_sync && scl_prev;
  assign bus_start = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign bus_stop = scl_sync && scl_prev && !sda_prev && sda_sync;

  // ********************************************************
  // control register
  // ********************************************************
  assign ctrl_wr = WR_I && hit(isct_pkg::CTRL_OFS);
  assign busy = bus_busy || (m_state != M_IDLE);
  assign slave_on = ctl_enable && !ctl_master && !ctl_abort;

  always_comb
  begin
    next_enable = ctl_enable;
    next_master = ctl_master;
    // enable stays writable during a transfer only to back out of an abort
    if (ctrl_wr && (!busy || ctl_abort))
    begin
      next_enable = WDATA_I[isct_pkg::CTRL_EN];
    end
    if (ctrl_wr && !busy)
    begin
      next_master = WDATA_I[isct_pkg::CTRL_MST];
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      ctl_enable <= 1'b0;
      ctl_master <= 1'b0;
      ctl_strs <= 1'b0;
      ctl_gcen <= 1'b0;
      ctl_stren <= 1'b0;
    end
    else
    begin
      ctl_enable <= next_enable;
      ctl_master <= next_master;
      if (ctrl_wr)
      begin
        ctl_strs <= WDATA_I[isct_pkg::CTRL_STRS];
        ctl_gcen <= WDATA_I[isct_pkg::CTRL_GCEN];
        ctl_stren <= WDATA_I[isct_pkg::CTRL_STREN];
      end
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      ctl_abort <= 1'b0;
    end
    else if (ctrl_wr && WDATA_I[isct_pkg::CTRL_ABORT])
    begin
      ctl_abort <= 1'b1;
    end
    else if (ctl_abort || !ctl_enable)
    begin
      // the abort itself completes in one cycle
      ctl_abort <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      ctl_start <= 1'b0;
    end
    else if (!next_enable || !next_master || ctl_abort)
    begin
      ctl_start <= 1'b0;
    end
    else if (ctrl_wr && WDATA_I[isct_pkg::CTRL_START] && WDATA_I[isct_pkg::CTRL_STOP])
    begin
      ctl_start <= 1'b0;
    end
    else if (ctrl_wr && WDATA_I[isct_pkg::CTRL_START] && !ctl_stop)
    begin
      ctl_start <= 1'b1;
    end
    else if (m_start_done)
    begin
      ctl_start <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      ctl_stop <= 1'b0;
    end
    else if (!next_enable || !next_master || ctl_abort)
    begin
      ctl_stop <= 1'b0;
    end
    else if (ctrl_wr && WDATA_I[isct_pkg::CTRL_START] && WDATA_I[isct_pkg::CTRL_STOP])
    begin
      ctl_stop <= 1'b0;
    end
    else if (ctrl_wr && WDATA_I[isct_pkg::CTRL_STOP] && !ctl_start)
    begin
      ctl_stop <= 1'b1;
    end
    else if (m_stop_done || to_expire)
    begin
      ctl_stop <= 1'b0;
    end
  end

  // ********************************************************
  // timing, timeout and transmit registers
  // ********************************************************
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      timing <= isct_pkg::TIMING_RESET;
    end
    else if (WR_I && hit(isct_pkg::TIMING_OFS) && !busy)
    begin
      timing <= WDATA_I;
    end
  end

  assign lo_eff = at_least(timing[7:0], isct_pkg::LOW_MIN);
  assign hi_eff = at_least(timing[15:8], isct_pkg::HIGH_MIN);

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      to_limit <= isct_pkg::TIMEOUT_RESET;
      tx_data <= 8'h00;
    end
    else
    begin
      if (WR_I && hit(isct_pkg::TIMEOUT_OFS))
      begin
        to_limit <= WDATA_I[7:0];
      end
      if (WR_I && hit(isct_pkg::TXDATA_OFS) && !tx_pending)
      begin
        tx_data <= WDATA_I[7:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      tx_pending <= 1'b0;
    end
    else if (!ctl_enable || ctl_abort)
    begin
      tx_pending <= 1'b0;
    end
    else if (WR_I && hit(isct_pkg::TXDATA_OFS))
    begin
      tx_pending <= 1'b1;
    end
    else if (m_state == M_HOLD && !ctl_stop)
    begin
      tx_pending <= 1'b0;
    end
  end

  // ********************************************************
  // stop timeout, counted in bit periods
  // ********************************************************
  // widened before the product so no carry is lost
  assign to_span = ({11'h000, to_limit} + 19'h00001)
    * ({11'h000, lo_eff} + {11'h000, hi_eff} + 19'h00002);
  assign to_expire = ctl_stop && ctl_master && (to_limit != 8'h00) && (to_cnt >= to_span);

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      to_cnt <= 19'h00000;
    end
    else if (!ctl_stop || scl_fall || to_expire)
    begin
      to_cnt <= 19'h00000;
    end
    else if (to_limit != 8'h00)
    begin
      to_cnt <= to_cnt + 19'h00001;
    end
  end

  // ********************************************************
  // master clock and condition generator
  // ********************************************************
  assign m_start_done = (m_state == M_START) && (m_cnt == 8'h00);
  assign m_stop_done = ((m_state == M_STOP_END) && (m_cnt == 8'h00))
    || ((m_state == M_IDLE) && ctl_stop);

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      m_state <= M_IDLE;
      m_cnt <= 8'h00;
      m_bit <= 4'h0;
      m_shift <= 8'h00;
      m_scl_low <= 1'b0;
      m_sda_low <= 1'b0;
      last_ack <= 1'b1;
    end
    else if (!ctl_enable || ctl_abort || to_expire)
    begin
      // release both lines at once; the bus is left as it stands
      m_state <= M_IDLE;
      m_scl_low <= 1'b0;
      m_sda_low <= 1'b0;
    end
    else
    begin
      case (m_state)
        M_IDLE:
        begin
          if (ctl_master && ctl_start && !bus_busy)
          begin
            m_sda_low <= 1'b1;
            m_cnt <= hi_eff;
            m_state <= M_START;
          end
        end
        M_START:
        begin
          m_cnt <= m_cnt - 8'h01;
          if (m_cnt == 8'h00)
          begin
            m_scl_low <= 1'b1;
            m_state <= M_HOLD;
          end
        end
        M_HOLD:
        begin
          if (ctl_stop)
          begin
            m_sda_low <= 1'b1;
            m_cnt <= lo_eff;
            m_state <= M_STOP_LOW;
          end
          else if (tx_pending)
          begin
            m_shift <= tx_data;
            m_sda_low <= !tx_data[7];
            m_bit <= 4'h0;
            m_cnt <= lo_eff;
            m_state <= M_LOW;
          end
        end
        M_LOW:
        begin
          m_cnt <= m_cnt - 8'h01;
          if (m_cnt == 8'h00)
          begin
            m_scl_low <= 1'b0;
            m_cnt <= hi_eff;
            m_state <= M_HIGH;
          end
        end
        M_HIGH:
        begin
          // a slave holding SCL low delays the high count
          if (scl_sync)
          begin
            m_cnt <= m_cnt - 8'h01;
            if (m_cnt == 8'h00)
            begin
              m_scl_low <= 1'b1;
              m_cnt <= lo_eff;
              if (m_bit == isct_pkg::ACK_BIT)
              begin
                last_ack <= sda_sync;
                m_sda_low <= 1'b0;
                m_state <= M_HOLD;
              end
              else
              begin
                m_bit <= m_bit + 4'h1;
                m_shift <= {m_shift[6:0], 1'b0};
                m_sda_low <= (m_bit == isct_pkg::LAST_DATA_BIT) ? 1'b0 : !m_shift[6];
                m_state <= M_LOW;
              end
            end
          end
        end
        M_STOP_LOW:
        begin
          m_cnt <= m_cnt - 8'h01;
          if (m_cnt == 8'h00)
          begin
            m_scl_low <= 1'b0;
            m_cnt <= hi_eff;
            m_state <= M_STOP_HIGH;
          end
        end
        M_STOP_HIGH:
        begin
          if (scl_sync)
          begin
            m_cnt <= m_cnt - 8'h01;
            if (m_cnt == 8'h00)
            begin
              m_sda_low <= 1'b0;
              m_cnt <= hi_eff;
              m_state <= M_STOP_END;
            end
          end
        end
        M_STOP_END:
        begin
          m_cnt <= m_cnt - 8'h01;
          if (m_cnt == 8'h00)
          begin
            m_state <= M_IDLE;
          end
        end
        default:
        begin
          m_state <= M_IDLE;
        end
      endcase
    end
  end

  // ********************************************************
  // bus watch, general call and stretching as slave
  // ********************************************************
  assign s_fall_no = s_cnt + 4'h1;
  assign stretch_at = ctl_strs ? isct_pkg::STRETCH_AT_8 : isct_pkg::STRETCH_AT_9;
  assign gc_ev = slave_on && s_active && scl_fall && ctl_gcen
    && (s_fall_no == isct_pkg::ACK_BIT) && (s_shift == isct_pkg::GCALL_ADDR);
  assign stretch_ev = slave_on && s_active && scl_fall && ctl_stren
    && (s_fall_no == stretch_at);

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      bus_busy <= 1'b0;
    end
    else if (!ctl_enable || ctl_abort || bus_stop)
    begin
      bus_busy <= 1'b0;
    end
    else if (bus_start)
    begin
      bus_busy <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      s_active <= 1'b0;
      s_cnt <= 4'h0;
      s_shift <= 8'h00;
      s_ack <= 1'b0;
    end
    else if (!slave_on || bus_stop)
    begin
      s_active <= 1'b0;
      s_ack <= 1'b0;
    end
    else if (bus_start)
    begin
      s_active <= 1'b1;
      // the start's own scl fall brings the count to zero
      s_cnt <= '1;
      s_ack <= 1'b0;
    end
    else if (s_active && scl_rise && (s_cnt <= isct_pkg::LAST_DATA_BIT))
    begin
      s_shift <= {s_shift[6:0], sda_sync};
    end
    else if (s_active && scl_fall)
    begin
      s_cnt <= s_fall_no;
      if (gc_ev)
      begin
        s_ack <= 1'b1;
      end
      if (s_fall_no == isct_pkg::STRETCH_AT_9)
      begin
        // only the address byte is watched here
        s_ack <= 1'b0;
        s_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      s_hold <= 1'b0;
    end
    else if (!slave_on)
    begin
      s_hold <= 1'b0;
    end
    else if (stretch_ev)
    begin
      s_hold <= 1'b1;
    end
    else if (!int_status[isct_pkg::INT_STRETCH])
    begin
      s_hold <= 1'b0;
    end
  end

  // ********************************************************
  // interrupts
  // ********************************************************
  always_comb
  begin
    events = '0;
    events[isct_pkg::INT_START] = m_start_done;
    events[isct_pkg::INT_STOP] = m_stop_done;
    events[isct_pkg::INT_TIMEOUT] = to_expire;
    events[isct_pkg::INT_GCALL] = gc_ev;
    events[isct_pkg::INT_STRETCH] = stretch_ev;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      int_status <= '0;
      int_mask <= '0;
    end
    else
    begin
      // a new event wins over a clear in the same cycle
      if (WR_I && hit(isct_pkg::INT_STAT_OFS))
      begin
        int_status <= (int_status & ~WDATA_I[INT_W_L-1:0]) | events;
      end
      else
      begin
        int_status <= int_status | events;
      end
      if (WR_I && hit(isct_pkg::INT_MASK_OFS))
      begin
        int_mask <= WDATA_I[INT_W_L-1:0];
      end
    end
  end

  // ********************************************************
  // read port
  // ********************************************************
  always_comb
  begin
    next_rdata = 16'h0000;
    if (hit(isct_pkg::CTRL_OFS))
    begin
      // bits 14:10 stay zero
      next_rdata[isct_pkg::CTRL_EN] = ctl_enable;
      next_rdata[isct_pkg::CTRL_MST] = ctl_master;
      next_rdata[isct_pkg::CTRL_STRS] = ctl_strs;
      next_rdata[isct_pkg::CTRL_START] = ctl_start;
      next_rdata[isct_pkg::CTRL_STOP] = ctl_stop;
      next_rdata[isct_pkg::CTRL_GCEN] = ctl_gcen;
      next_rdata[isct_pkg::CTRL_STREN] = ctl_stren;
      next_rdata[isct_pkg::CTRL_ABORT] = ctl_abort;
    end
    else if (hit(isct_pkg::TIMING_OFS))
    begin
      next_rdata = timing;
    end
    else if (hit(isct_pkg::TIMEOUT_OFS))
    begin
      next_rdata[7:0] = to_limit;
    end
    else if (hit(isct_pkg::TXDATA_OFS))
    begin
      next_rdata[7:0] = tx_data;
    end
    else if (hit(isct_pkg::STATE_OFS))
    begin
      next_rdata[isct_pkg::ST_BUSY] = busy;
      next_rdata[isct_pkg::ST_ACK] = last_ack;
      next_rdata[isct_pkg::ST_TXPEND] = tx_pending;
      next_rdata[isct_pkg::ST_SCL] = scl_sync;
      next_rdata[isct_pkg::ST_SDA] = sda_sync;
    end
    else if (hit(isct_pkg::INT_STAT_OFS))
    begin
      next_rdata[INT_W_L-1:0] = int_status;
    end
    else if (hit(isct_pkg::INT_MASK_OFS))
    begin
      next_rdata[INT_W_L-1:0] = int_mask;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      RDATA_O <= 16'h0000;
    end
    else
    begin
      RDATA_O <= RD_I ? next_rdata : 16'h0000;
    end
  end

  assign IRQ_O = |(int_status & int_mask);
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_O = m_scl_low || s_hold;
  assign SDA_OE_O = m_sda_low || s_ack;
endmodule
`default_nettype wire

// ---- testbench/isct_bus_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// far side: outside master and slave
// ****************************************
module isct_bus_partner (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_en_i,
  input wire logic hold_i,
  output logic scl_pull_o,
  output logic sda_pull_o
);
  logic scl_m = 1'b0;
  logic sda_m = 1'b0;
  logic ack = 1'b0;
  int cnt = 0;
  int falls = 0;
  // hold models a slave that answers very slowly
  assign scl_pull_o = scl_m | hold_i;
  assign sda_pull_o = sda_m | ack;
  always @(negedge sda_i)
  begin
    // let a falling scl of the same step settle first
    #1;
    if (scl_i)
      cnt = 0;
  end
  // start fall counts too, so the ack slot is fall nine
  always @(negedge scl_i)
  begin
    cnt = cnt + 1;
    ack = ack_en_i && cnt == 9;
  end
  // link clock runs only inside a frame, 320 ns period
  task send(input logic [7:0] b);
    int i;
    falls = 0;
    sda_m = 1'b1;
    #160 scl_m = 1'b1;
    for (i = 0; i < 9; i++)
    begin
      #80 sda_m = (i < 8) ? ~b[7-i] : 1'b0;
      #80 scl_m = 1'b0;
      wait (scl_i);
      #160 scl_m = 1'b1;
      falls++;
    end
    #80 sda_m = 1'b1;
    #80 scl_m = 1'b0;
    wait (scl_i);
    #160 sda_m = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/isct_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// port-level checks of the control block
// ****************************************
module isct_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SCL_OE_O,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic IRQ_O
);
  logic tm_wr;
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  // timing register untouched since reset
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
      tm_wr <= 1'b0;
    else if (WR_I && ADDR_I == isct_pkg::TIMING_OFS)
      tm_wr <= 1'b1;
  end
  sequence ctl_rd;
    RD_I && ADDR_I == isct_pkg::CTRL_OFS;
  endsequence
  sequence both_wr;
    WR_I && ADDR_I == isct_pkg::CTRL_OFS && WDATA_I[7:6] == 2'h3;
  endsequence
  sequence off_wr;
    WR_I && ADDR_I == isct_pkg::CTRL_OFS && WDATA_I[15] && !WDATA_I[0];
  endsequence
  a_rdata_idle: assert property (!RD_I |=> RDATA_O == 16'h0000)
    else $error("read data seen outside a read");
  a_ctrl_reserved: assert property (ctl_rd |=> RDATA_O[14:10] == 5'h00)
    else $error("control reserved bits not zero");
  a_timing_reset: assert property ((RD_I && ADDR_I == isct_pkg::TIMING_OFS && !tm_wr)
    |=> RDATA_O == 16'h0204) else $error("timing reset value wrong");
  a_both_clear: assert property (both_wr ##1 ctl_rd |=> RDATA_O[7:6] == 2'h0)
    else $error("start and stop not both cleared");
  a_stop_off: assert property (off_wr ##1 ctl_rd |=> !RDATA_O[7])
    else $error("stop kept while disabled");
  // an abort may cut a low phase short
  a_low_min: assert property (disable iff (RST_I || WR_I && WDATA_I[15])
    $rose(SCL_OE_O) |-> SCL_OE_O [*5]) else $error("scl low phase too short");
  a_high_min: assert property ($fell(SCL_OE_O) |-> !SCL_OE_O [*3])
    else $error("scl high phase too short");
  a_irq_mask: assert property ((WR_I && ADDR_I == isct_pkg::INT_MASK_OFS
    && WDATA_I[4:0] == 5'h00) |=> !IRQ_O) else $error("masked interrupt still high");
endmodule
bind isct_top isct_sva #(.ADDR_W(ADDR_W)) isct_sva_inst (.SYS_CLK_I(SYS_CLK_I),
  .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O),
  .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ---- testbench/isct_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// stimulus, partner and result monitor
// ****************************************
module isct_top_tb;
  localparam logic [7:0] CT = isct_pkg::CTRL_OFS;
  localparam logic [7:0] TM = isct_pkg::TIMING_OFS;
  localparam logic [7:0] IS = isct_pkg::INT_STAT_OFS;
  localparam logic [7:0] IM = isct_pkg::INT_MASK_OFS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ack_en = 1'b0;
  logic hold = 1'b0;
  logic rd_d = 1'b0;
  logic prev = 1'b0;
  logic [15:0] seed = 16'h9F09;
  logic [15:0] rdata;
  logic p_scl, p_sda, scl_oe, sda_oe, scl_o, sda_o, irq;
  wire logic scl_w = ~(scl_oe & ~scl_o | p_scl);
  wire logic sda_w = ~(sda_oe & ~sda_o | p_sda);
  wire logic [2:0] obs = {irq, sda_oe, scl_oe};
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int run = 1;
  int e;
  logic [31:0] ent;
  logic [31:0] exp_q[$];
  int lo_q[$];
  int hi_q[$];
  initial forever #20 clk = ~clk;
  isct_top isct_top_inst (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_O(scl_oe),
    .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .IRQ_O(irq));
  isct_bus_partner isct_bus_partner_inst (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en),
    .hold_i(hold), .scl_pull_o(p_scl), .sda_pull_o(p_sda));
  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function logic [15:0] xs;
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction
  // strobes stay up until the next op or wait lowers them
  task wr_r(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task rd_r(input logic [7:0] a, input logic [15:0] m, input logic [15:0] x);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    exp_q.push_back({m, x});
    @(posedge clk);
  endtask
  task wt(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task wait_for(input int s, input logic v);
    int i;
    wr <= 1'b0;
    rd <= 1'b0;
    i = 0;
    do
    begin
      @(negedge clk);
      i++;
    end
    while (obs[s] !== v && i < 1000);
    if (obs[s] !== v)
    begin
      miscompares++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask
  task pins(input logic [15:0] x);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    chk("pins", {7'h00, 4'(isct_bus_partner_inst.falls), sda_o, scl_o, obs}, x);
    @(posedge clk);
  endtask
  task xfer(input logic [15:0] t, input logic [7:0] b);
    wr_r(TM, t);
    rd_r(TM, 16'hFFFF, t);
    wr_r(IS, 16'h001F);
    wr_r(isct_pkg::TXDATA_OFS, {8'h00, b});
    wr_r(CT, 16'h0043);
    wr_r(CT, 16'h0083);
    rd_r(CT, 16'h0080, 16'h0000);
    wait_for(1, 1'b1);
    wr_r(TM, 16'h0000);
    rd_r(TM, 16'hFFFF, t);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    wt(1);
    repeat (8) lo_q.push_back(int'(t[7:0] < 8'h04 ? 8'h04 : t[7:0]) + 1);
    repeat (9) hi_q.push_back(int'(t[15:8] < 8'h02 ? 8'h02 : t[15:8]) + 1);
    repeat (8)
    begin
      wait_for(0, 1'b1);
      wait_for(0, 1'b0);
    end
    wait_for(0, 1'b1);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      tally_and_finish();
    end
    rd_d <= rd;
  end
  // read results and scl phase lengths, oldest note first
  always @(posedge clk)
  begin
    if (rd_d)
    begin
      ent = exp_q.pop_front();
      chk("rdata", rdata & ent[31:16], ent[15:0]);
    end
    if (scl_oe === prev)
      run++;
    else
    begin
      if (prev && lo_q.size() > 0)
        chk("scl_low", 16'(run), 16'(lo_q.pop_front()));
      if (!prev && hi_q.size() > 0)
      begin
        e = hi_q.pop_front();
        // sync of the released line adds two or three cycles
        chk("scl_high", (run >= e + 2 && run <= e + 3) ? 16'(e) : 16'(run), 16'(e));
      end
      run = 1;
      prev = scl_oe;
    end
  end
  initial
  begin
    int i;
    logic [15:0] v;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_r(TM, 16'hFFFF, 16'h0204);
    rd_r(8'h1F, 16'hFFFF, 16'h0000);
    wr_r(CT, 16'hFFFF);
    rd_r(CT, 16'h7FFF, 16'h0313);
    wr_r(CT, 16'h8000);
    rd_r(CT, 16'h7FFF, 16'h0000);
    wt(2);
    rd_r(CT, 16'hFFFF, 16'h0000);
    wr_r(CT, 16'h0081);
    rd_r(CT, 16'hFFFF, 16'h0001);
    wr_r(IM, 16'h0000);
    ack_en <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      v = xs();
      wr_r(isct_pkg::TIMEOUT_OFS, (i == 2) ? 16'h0001 : 16'h0000);
      xfer((i == 0) ? 16'h0100 : {6'h00, v[9:8], 5'h00, v[2:0]}, v[15:8]);
      hold <= (i == 2);
      wr_r(IM, (i == 2) ? 16'h0004 : 16'h0002);
      wr_r(CT, 16'h0083);
      wait_for(2, 1'b1);
      rd_r(CT, 16'hFFFF, 16'h0003);
      rd_r(IS, 16'hFFFF, (i == 2) ? 16'h0005 : 16'h0003);
      wr_r(IS, 16'h001F);
      hold <= 1'b0;
      wr_r(CT, 16'h8003);
      wt(2);
      rd_r(CT, 16'hFFFF, 16'h0003);
      wt(1);
      chk("irq", {15'h0000, irq}, 16'h0000);
    end
    ack_en <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      wr_r(CT, (i == 0) ? 16'h0311 : 16'h0201);
      wr_r(IS, 16'h001F);
      wr_r(IM, 16'h0010);
      wt(1);
      fork
        isct_bus_partner_inst.send(8'h00);
        begin
          wait_for(2, 1'b1);
          pins((i == 0) ? 16'h0107 : 16'h0125);
          rd_r(IS, 16'h0018, (i == 0) ? 16'h0018 : 16'h0010);
          wr_r(IS, 16'h0010);
          wt(1);
        end
      join
      wt(2);
      pins(16'h0120);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
